// file: include/cpu_exec_defines.svh
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH
// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define FLAG_C 3'd0
`define FLAG_Z 3'd1
`define FLAG_N 3'd2
`define FLAG_V 3'd3
`define FLAG_S 3'd4
`define FLAG_H 3'd5
`define FLAG_T 3'd6
`define FLAG_I 3'd7
// ----------------------------------------
// register map (byte addresses, wishbone)
// ----------------------------------------
`define REG_INSTR 4'h0
`define REG_OPERAND 4'h4
`define REG_FLAGS 4'h8
`define REG_PC 4'hc
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define FLAGS_RESET 8'h00
`define PC_RESET 16'h0000
`define SP_RESET 16'h00ff
`define IO_BIT_LIMIT 6'h1f
`define NUM_WREGS 16
`define DMEM_WORDS 256
`define IO_WORDS 64
`endif

// file: include/cpu_exec_pkg.sv
package cpu_exec_pkg;
  // operation selected by software through the instruction register
  typedef enum logic [4:0] {
    op_nop, op_branch_flag, op_shift_left_logical, op_shift_right_logical,
    op_rotate_left_carry, op_rotate_right_carry, op_io_bit_set, op_io_bit_clear,
    op_bit_to_transfer_flag, op_transfer_flag_to_bit, op_flag_set, op_flag_clear,
    op_irq_global_on, op_irq_global_off, op_indirect_load, op_indirect_store,
    op_direct_load, op_direct_store, op_io_in, op_io_out, op_push, op_pop,
    op_watchdog_restart, op_sleep, op_break
  } opcode_e;
  // pointer addressing mode of indirect transfers
  typedef enum logic [1:0] {ptr_plain, ptr_post_inc, ptr_pre_dec} ptr_mode_e;
  // decoded instruction word
  typedef struct packed {
    opcode_e op;
    ptr_mode_e mode;
    logic [1:0] ptr_sel;
    logic [3:0] reg_d;
    logic [2:0] bit_sel;
    logic branch_when;
  } instr_s;
  // memory request toward the storage modules
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_s;
endpackage

// file: design/data_ram.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpu_exec_defines.svh"
// data memory: combinational read, clocked write
module data_ram #(
  parameter int WORDS = `DMEM_WORDS
) (
  input wire logic clk,
  input wire logic ce,
  input wire cpu_exec_pkg::mem_req_s req,
  output logic [7:0] rdata
);
  // storage array
  logic [7:0] mem_reg [WORDS];
  assign rdata = mem_reg[req.addr];
  // ----------------------------------------
  // write port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (ce && req.we) begin
      mem_reg[req.addr] <= req.wdata;
    end
  end
endmodule
`default_nettype wire

// file: design/io_space.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpu_exec_defines.svh"
// i/o locations; single-bit writes touch only the addressed bit
module io_space #(
  parameter int WORDS = `IO_WORDS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire cpu_exec_pkg::mem_req_s req,
  input wire logic bit_we,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  output logic [7:0] rdata
);
  logic [7:0] io_reg [WORDS];
  assign rdata = io_reg[req.addr[5:0]];
  // ----------------------------------------
  // byte and bit writes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < WORDS; i++) io_reg[i] <= 8'h00;
    end else if (ce && req.we) begin
      io_reg[req.addr[5:0]] <= req.wdata;
    end else if (ce && bit_we) begin
      io_reg[req.addr[5:0]][bit_sel] <= bit_val;
    end
  end
endmodule
`default_nettype wire

// file: design/cpu_exec_core.sv
// Notes on behaviour
// - half-carry branch: pc plus offset plus one
// - transfer-flag branch relative, one/two cycles
// - overflow-flag branch relative, one/two cycles
// - interrupt-flag branch relative, one/two cycles
// - left shift, zero in, flags updated
// - right shift, zero in bit7, flags
// - rotate left through carry, flags
// - rotate right through carry, flags
// - io bit set/clear, flags untouched
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - single flag set or clear instructions
// - global interrupt enable/disable, one cycle
// - indirect load, post-increment takes two cycles
// - pre-decrement load: decrement then read
// - indirect store, pre-decrement two cycles
// - direct load/store one byte, one cycle
// - io in/out one byte, no flags
// - push/pop two cycles, flags unchanged
// - control instructions one cycle, flags kept
// - bit ops only bit, only below 0x20
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_exec_defines.svh"
module cpu_exec_core #(
  parameter int NREGS = `NUM_WREGS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] status_flags_register,
  output logic [15:0] pc_out,
  output logic busy_out,
  output logic watchdog_restart_op,
  output logic sleep_req,
  output logic break_req
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {st_idle, st_exec, st_final} state_e;
  state_e state_reg;
  cpu_exec_pkg::instr_s ins_reg;        // latched instruction
  logic [7:0] operand_reg;              // offset, address or io location
  logic [7:0] status_flags_register_reg;                 // status flags
  logic [15:0] pc_reg;                  // program counter
  logic [15:0] sp_reg;                  // stack pointer
  logic [7:0] wreg [NREGS];             // working registers
  logic [1:0] cyc_reg;                  // cycles left
  logic [31:0] rdat_reg;
  logic ack_reg, busy_reg, wdr_reg, slp_reg, brk_reg;
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic wr_instr = bus_req && wb_we_i && wb_adr_i == `REG_INSTR && wb_sel_i[0];
  wire logic wr_operand = bus_req && wb_we_i && wb_adr_i == `REG_OPERAND && wb_sel_i[0];
  wire logic wr_flags = bus_req && wb_we_i && wb_adr_i == `REG_FLAGS && wb_sel_i[0];
  wire logic start = wr_instr && state_reg == st_idle;
  // instruction word layout: op[4:0] mode[6:5] ptr[8:7] rd[12:9] bit[15:13] when[16]
  cpu_exec_pkg::instr_s new_ins;
  // fields repacked so that op[4:0] of the bus word lands in the struct's top bits
  assign new_ins = cpu_exec_pkg::instr_s'({wb_dat_i[4:0], wb_dat_i[6:5], wb_dat_i[8:7],
                                           wb_dat_i[12:9], wb_dat_i[15:13], wb_dat_i[16]});
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] ptr_of(input logic [1:0] sel, input logic [7:0] lo,
                                         input logic [7:0] hi);
    ptr_of = {hi, lo};
  endfunction
  // pointer pairs live in regs 10/11, 12/13, 14/15; ptr_sel 3 wraps to regs 0/1
  wire logic [3:0] plo = 4'(4'd10 + {1'b0, ins_reg.ptr_sel, 1'b0});
  wire logic [3:0] phi = 4'(plo + 4'd1);
  wire logic [15:0] ptr = ptr_of(ins_reg.ptr_sel, wreg[plo], wreg[phi]);
  wire logic [15:0] ptr_inc = 16'(ptr + 16'd1);
  wire logic [15:0] ptr_dec = 16'(ptr - 16'd1);
  wire logic [7:0] rd = wreg[ins_reg.reg_d];
  wire logic c_old = status_flags_register_reg[`FLAG_C];
  // shift/rotate results
  logic [7:0] sh_res;
  logic sh_c;
  always_comb begin
    sh_res = rd;
    sh_c = c_old;
    unique case (ins_reg.op)
      cpu_exec_pkg::op_shift_left_logical: {sh_c, sh_res} = {rd, 1'b0};
      cpu_exec_pkg::op_shift_right_logical: {sh_res, sh_c} = {1'b0, rd};
      cpu_exec_pkg::op_rotate_left_carry: {sh_c, sh_res} = {rd, c_old};
      cpu_exec_pkg::op_rotate_right_carry: {sh_res, sh_c} = {c_old, rd};
      default: sh_res = rd;
    endcase
  end
  wire logic is_left = ins_reg.op == cpu_exec_pkg::op_shift_left_logical ||
                       ins_reg.op == cpu_exec_pkg::op_rotate_left_carry;
  wire logic sh_n = sh_res[7];
  wire logic sh_v = sh_n ^ sh_c;
  logic [7:0] sh_flags;
  always_comb begin
    sh_flags = status_flags_register_reg;
    sh_flags[`FLAG_Z] = sh_res == 8'h00;
    sh_flags[`FLAG_C] = sh_c;
    sh_flags[`FLAG_N] = sh_n;
    sh_flags[`FLAG_V] = sh_v;
    // signed flag is not among the flags that shifts and rotates touch
    if (is_left) sh_flags[`FLAG_H] = rd[3];
  end
  // branch: tested flag chosen by bit_sel, taken when it equals branch_when
  wire logic br_taken = status_flags_register_reg[ins_reg.bit_sel] == ins_reg.branch_when;
  wire logic [15:0] br_target = 16'(pc_reg + {{8{operand_reg[7]}}, operand_reg} + 16'd1);
  wire logic [15:0] pc_step = 16'(pc_reg + 16'd1);
  // memory access address and io bit range check
  wire logic [15:0] mem_addr = ins_reg.mode == cpu_exec_pkg::ptr_pre_dec ? ptr_dec : ptr;
  wire logic io_bit_ok = operand_reg[5:0] <= `IO_BIT_LIMIT && operand_reg[7:6] == 2'b00;
  // ----------------------------------------
  // storage instances
  // ----------------------------------------
  cpu_exec_pkg::mem_req_s dreq, ioreq;
  logic [7:0] drdata, iordata;
  logic io_bwe;
  wire logic last = state_reg == st_exec && cyc_reg == 2'd1;
  wire logic is_op_ld = ins_reg.op == cpu_exec_pkg::op_indirect_load;
  wire logic is_op_st = ins_reg.op == cpu_exec_pkg::op_indirect_store;
  wire logic [15:0] sp_dec = 16'(sp_reg - 16'd1);
  wire logic [15:0] sp_inc = 16'(sp_reg + 16'd1);
  always_comb begin
    dreq = '0;
    ioreq = '0;
    io_bwe = 1'b0;
    unique case (ins_reg.op)
      cpu_exec_pkg::op_indirect_load: dreq.addr = mem_addr[7:0];
      cpu_exec_pkg::op_indirect_store: begin
        dreq = '{we: last, addr: mem_addr[7:0], wdata: rd};
      end
      cpu_exec_pkg::op_direct_load: dreq.addr = operand_reg;
      cpu_exec_pkg::op_direct_store: dreq = '{we: last, addr: operand_reg, wdata: rd};
      cpu_exec_pkg::op_push: dreq = '{we: last, addr: sp_reg[7:0], wdata: rd};
      cpu_exec_pkg::op_pop: dreq.addr = sp_inc[7:0];
      cpu_exec_pkg::op_io_in: ioreq.addr = operand_reg;
      cpu_exec_pkg::op_io_out: ioreq = '{we: last, addr: operand_reg, wdata: rd};
      cpu_exec_pkg::op_io_bit_set, cpu_exec_pkg::op_io_bit_clear: begin
        ioreq.addr = operand_reg;
        io_bwe = last && io_bit_ok;
      end
      default: dreq = '0;
    endcase
  end
  data_ram u_ram (
    .clk(clk),
    .ce(ce),
    .req(dreq),
    .rdata(drdata)
  );
  io_space u_io (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .req(ioreq),
    .bit_we(io_bwe),
    .bit_sel(ins_reg.bit_sel),
    .bit_val(ins_reg.op == cpu_exec_pkg::op_io_bit_set),
    .rdata(iordata)
  );
  // ----------------------------------------
  // cycle count per instruction
  // ----------------------------------------
  function automatic logic [1:0] cycles_of(input cpu_exec_pkg::instr_s i, input logic tk);
    unique case (i.op)
      cpu_exec_pkg::op_branch_flag: cycles_of = tk ? 2'd2 : 2'd1;
      cpu_exec_pkg::op_indirect_load: cycles_of = i.mode == cpu_exec_pkg::ptr_plain ? 2'd1 :
                                         (i.mode == cpu_exec_pkg::ptr_post_inc ? 2'd2 : 2'd3);
      cpu_exec_pkg::op_indirect_store: cycles_of =
        i.mode == cpu_exec_pkg::ptr_pre_dec ? 2'd2 : 2'd1;
      cpu_exec_pkg::op_push, cpu_exec_pkg::op_pop: cycles_of = 2'd2;
      default: cycles_of = 2'd1;
    endcase
  endfunction
  wire logic start_taken = status_flags_register_reg[new_ins.bit_sel] == new_ins.branch_when;
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= st_idle;
      cyc_reg <= 2'd0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        st_idle: if (start) begin
          state_reg <= st_exec;
          cyc_reg <= cycles_of(new_ins, start_taken);
          busy_reg <= 1'b1;
        end
        st_exec: if (cyc_reg == 2'd1) begin
          state_reg <= st_final;
        end else begin
          cyc_reg <= 2'(cyc_reg - 2'd1);
        end
        st_final: begin
          state_reg <= st_idle;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------
  // architectural state update on last cycle
  // ----------------------------------------
  logic [7:0] load_val;
  assign load_val = (ins_reg.op == cpu_exec_pkg::op_io_in) ? iordata : drdata;
  always_ff @(posedge clk) begin
    if (reset) begin
      status_flags_register_reg <= `FLAGS_RESET;
      pc_reg <= `PC_RESET;
      sp_reg <= `SP_RESET;
      ins_reg <= '0;
      operand_reg <= 8'h00;
      for (int i = 0; i < NREGS; i++) wreg[i] <= 8'h00;
      {wdr_reg, slp_reg, brk_reg} <= 3'b000;
    end else if (ce) begin
      {wdr_reg, slp_reg, brk_reg} <= 3'b000;
      if (start) ins_reg <= new_ins;
      if (wr_operand) operand_reg <= wb_dat_i[7:0];
      if (wr_flags && state_reg == st_idle) status_flags_register_reg <= wb_dat_i[7:0];
      if (last) begin
        pc_reg <= (ins_reg.op == cpu_exec_pkg::op_branch_flag && br_taken) ? br_target : pc_step;
        unique case (ins_reg.op)
          cpu_exec_pkg::op_shift_left_logical, cpu_exec_pkg::op_shift_right_logical,
          cpu_exec_pkg::op_rotate_left_carry, cpu_exec_pkg::op_rotate_right_carry: begin
            wreg[ins_reg.reg_d] <= sh_res;
            status_flags_register_reg <= sh_flags;
          end
          cpu_exec_pkg::op_bit_to_transfer_flag:
            status_flags_register_reg[`FLAG_T] <= rd[ins_reg.bit_sel];
          cpu_exec_pkg::op_transfer_flag_to_bit:
            wreg[ins_reg.reg_d][ins_reg.bit_sel] <= status_flags_register_reg[`FLAG_T];
          cpu_exec_pkg::op_flag_set: status_flags_register_reg[ins_reg.bit_sel] <= 1'b1;
          cpu_exec_pkg::op_flag_clear: status_flags_register_reg[ins_reg.bit_sel] <= 1'b0;
          cpu_exec_pkg::op_irq_global_on: status_flags_register_reg[`FLAG_I] <= 1'b1;
          cpu_exec_pkg::op_irq_global_off: status_flags_register_reg[`FLAG_I] <= 1'b0;
          cpu_exec_pkg::op_indirect_load, cpu_exec_pkg::op_direct_load,
          cpu_exec_pkg::op_io_in, cpu_exec_pkg::op_pop:
            wreg[ins_reg.reg_d] <= load_val;
          cpu_exec_pkg::op_push: sp_reg <= sp_dec;
          cpu_exec_pkg::op_watchdog_restart: wdr_reg <= 1'b1;
          cpu_exec_pkg::op_sleep: slp_reg <= 1'b1;
          cpu_exec_pkg::op_break: brk_reg <= 1'b1;
          // branches, stores and the rest: pc already chosen above, store pointers written back below
          default: ;
        endcase
        if (ins_reg.op == cpu_exec_pkg::op_pop) sp_reg <= sp_inc;
        // pointer write-back for post-increment and pre-decrement
        if ((is_op_ld || is_op_st) && ins_reg.mode != cpu_exec_pkg::ptr_plain) begin
          {wreg[phi], wreg[plo]} <= ins_reg.mode == cpu_exec_pkg::ptr_post_inc ?
                                    ptr_inc : ptr_dec;
        end
      end
    end
  end
  // ----------------------------------------
  // wishbone answer: ack one cycle after request
  // ----------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux = wb_adr_i == `REG_INSTR ? {31'h0, busy_reg} :
                  wb_adr_i == `REG_OPERAND ? {24'h0, operand_reg} :
                  wb_adr_i == `REG_FLAGS ? {24'h0, status_flags_register_reg} :
                  wb_adr_i == `REG_PC ? {16'h0, pc_reg} : 32'h0;
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else if (ce) begin
      ack_reg <= bus_req;
      if (bus_req) rdat_reg <= rd_mux;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign status_flags_register = status_flags_register_reg;
  assign pc_out = pc_reg;
  assign busy_out = busy_reg;
  assign watchdog_restart_op = wdr_reg;
  assign sleep_req = slp_reg;
  assign break_req = brk_reg;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);
  a_branch_untaken_pc: assert property (start && new_ins.op == cpu_exec_pkg::op_branch_flag
    && !start_taken |=> ##1 (pc_out == $past(pc_out, 2) + 16'd1)) else $error("untaken pc");
  a_busy_after_start: assert property (start |=> busy_out) else $error("busy not set");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
  a_flags_idle_hold: assert property (state_reg == st_idle && !wr_flags |=> $stable(status_flags_register_reg))
    else $error("flags moved");
  a_push_two_cycles: assert property (start && new_ins.op == cpu_exec_pkg::op_push
    |=> ##2 state_reg == st_final) else $error("push not two cycles");
  a_wdr_pulse_single: assert property (watchdog_restart_op |=> !watchdog_restart_op)
    else $error("restart pulse too long");
  c_branch: cover property (last && ins_reg.op == cpu_exec_pkg::op_branch_flag && br_taken);
  c_push: cover property (last && ins_reg.op == cpu_exec_pkg::op_push);
  c_ld_dec: cover property (last && is_op_ld && ins_reg.mode == cpu_exec_pkg::ptr_pre_dec);
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1; // clock enable held on
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic [7:0] flags;
  logic [15:0] pc;
  logic busy;
  logic wdr_p;
  logic slp_p;
  logic brk_p;
  // expected read values, oldest first
  typedef struct packed {logic [31:0] mask; logic [31:0] val;} exp_s;
  exp_s expq[$];
  int mismatches = 0;
  int compares = 0;
  int seed;
  int n_wdr = 0;
  int n_slp = 0;
  int n_brk = 0;
  logic [31:0] rdat;
  cpu_exec_core cpu_exec_core_i (.clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .status_flags_register(flags), .pc_out(pc),
    .busy_out(busy), .watchdog_restart_op(wdr_p), .sleep_req(slp_p), .break_req(brk_p));
  // ----------------------------------------
  // clock and monitors
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  // pops the oldest note on each read answer, compares only when its mask is not zero
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      exp_s e;
      e = expq.pop_front();
      if (e.mask != 32'h0) begin
        compares++;
        if ((dat_o & e.mask) !== (e.val & e.mask)) begin
          mismatches++;
          $display("MISMATCH t=%0t got=%h exp=%h", $time, dat_o & e.mask, e.val & e.mask);
        end
      end
    end
  end
  // counts the control pulses
  always @(posedge clk) begin
    if (wdr_p === 1'b1) n_wdr++;
    if (slp_p === 1'b1) n_slp++;
    if (brk_p === 1'b1) n_brk++;
  end
  // ----------------------------------------
  // bus and operation tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [31:0] e);
    if (!w) expq.push_back('{m, e});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= d;
    // the ack ends the wait for the answer; the watchdog ends it if no ack comes
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // operand first, then the instruction, then poll busy
  task automatic ex(input cpu_exec_pkg::opcode_e op, input logic [1:0] md, input logic [1:0] p,
                    input logic [3:0] rd, input logic [2:0] b, input logic bw,
                    input logic [7:0] opnd);
    wb(1'b1, 4'h4, {24'h0, opnd}, 32'h0, 32'h0);
    wb(1'b1, 4'h0, {15'h0, bw, b, rd, p, md, op}, 32'h0, 32'h0);
    // busy pin must be up when the instruction write is answered
    compares++;
    if (busy !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b1);
    end
    do begin
      wb(1'b0, 4'h0, 32'h0, 32'h0, 32'h0);
    end while (rdat[0] !== 1'b0);
  endtask
  // loads a register one bit at a time through the transfer flag
  task automatic set_reg(input logic [3:0] r, input logic [7:0] v);
    for (int b = 0; b < 8; b++) begin
      wb(1'b1, 4'h8, {25'h0, v[b], 6'h0}, 32'h0, 32'h0);
      ex(cpu_exec_pkg::op_transfer_flag_to_bit, 2'd0, 2'd0, r, b[2:0], 1'b0, 8'h0);
    end
  endtask
  // checks a register bit by bit through the transfer flag
  task automatic chk_reg(input logic [3:0] r, input logic [7:0] v);
    for (int b = 0; b < 8; b++) begin
      ex(cpu_exec_pkg::op_bit_to_transfer_flag, 2'd0, 2'd0, r, b[2:0], 1'b0, 8'h0);
      wb(1'b0, 4'h8, 32'h0, 32'h40, {25'h0, v[b], 6'h0});
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    logic [7:0] f, v, r, e, off;
    logic [15:0] xp;
    logic [2:0] b3;
    logic c;
    logic hup;
    cpu_exec_pkg::opcode_e sop;
    seed = 32'h0b0f05a7;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped read
    wb(1'b0, 4'h8, 32'h0, 32'hff, 32'h0);
    wb(1'b0, 4'hc, 32'h0, 32'hffff, 32'h0);
    wb(1'b0, 4'h2, 32'h0, 32'hffffffff, 32'h0);
    // single flag set and clear, flags 0 to 6
    for (int b = 0; b < 7; b++) begin
      f = $random(seed);
      wb(1'b1, 4'h8, {24'h0, f}, 32'h0, 32'h0);
      ex(cpu_exec_pkg::op_flag_set, 2'd0, 2'd0, 4'h0, b[2:0], 1'b0, 8'h0);
      wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f | (8'h1 << b)});
      ex(cpu_exec_pkg::op_flag_clear, 2'd0, 2'd0, 4'h0, b[2:0], 1'b0, 8'h0);
      wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f & ~(8'h1 << b)});
    end
    f = f & ~(8'h1 << 6);
    ex(cpu_exec_pkg::op_irq_global_on, 2'd0, 2'd0, 4'h0, 3'd0, 1'b0, 8'h0);
    wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f | 8'h80});
    ex(cpu_exec_pkg::op_irq_global_off, 2'd0, 2'd0, 4'h0, 3'd0, 1'b0, 8'h0);
    f = f & 8'h7f;
    wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f});
    // control operations leave the flags; restart, sleep and break each pulse once
    ex(cpu_exec_pkg::op_nop, 2'd0, 2'd0, 4'h0, 3'd0, 1'b0, 8'h0);
    ex(cpu_exec_pkg::op_watchdog_restart, 2'd0, 2'd0, 4'h0, 3'd0, 1'b0, 8'h0);
    ex(cpu_exec_pkg::op_sleep, 2'd0, 2'd0, 4'h0, 3'd0, 1'b0, 8'h0);
    ex(cpu_exec_pkg::op_break, 2'd0, 2'd0, 4'h0, 3'd0, 1'b0, 8'h0);
    wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f});
    compares++;
    if (n_wdr != 1 || n_slp != 1 || n_brk != 1) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {n_wdr[7:0], n_slp[7:0], n_brk[7:0]},
               24'h010101);
    end
    // branches on half-carry, transfer, overflow, interrupt flags
    for (int i = 0; i < 16; i++) begin
      b3 = (i % 4 == 0) ? 3'd5 : (i % 4 == 1) ? 3'd6 : (i % 4 == 2) ? 3'd3 : 3'd7;
      f = $random(seed);
      f[b3] = i[3];
      off = $random(seed);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      wb(1'b1, 4'h8, {24'h0, f}, 32'h0, 32'h0);
      ex(cpu_exec_pkg::op_branch_flag, 2'd0, 2'd0, 4'h0, b3, i[2], off);
      wb(1'b0, 4'hc, 32'h0, 32'hffff,
         (i[3] == i[2]) ? {16'h0, {{8{off[7]}}, off} + 16'h1} : 32'h1);
      // the pc pin must agree with the expected target
      xp = (i[3] == i[2]) ? 16'({{8{off[7]}}, off} + 16'h1) : 16'h1;
      compares++;
      if (pc !== xp) begin
        mismatches++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, pc, xp);
      end
    end
    // shifts and rotates through carry
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h80 : 8'($random(seed));
      f = $random(seed);
      set_reg(4'h3, v);
      wb(1'b1, 4'h8, {24'h0, f}, 32'h0, 32'h0);
      hup = 1'b1;
      case (i % 4)
        0: begin sop = cpu_exec_pkg::op_shift_left_logical; r = {v[6:0], 1'b0}; c = v[7]; end
        1: begin sop = cpu_exec_pkg::op_shift_right_logical; r = {1'b0, v[7:1]}; c = v[0];
          hup = 1'b0; end
        2: begin sop = cpu_exec_pkg::op_rotate_left_carry; r = {v[6:0], f[0]}; c = v[7]; end
        default: begin sop = cpu_exec_pkg::op_rotate_right_carry; r = {f[0], v[7:1]};
          c = v[0]; hup = 1'b0; end
      endcase
      ex(sop, 2'd0, 2'd0, 4'h3, 3'd0, 1'b0, 8'h0);
      e = f;
      e[0] = c;
      e[1] = (r == 8'h0);
      e[2] = r[7];
      e[3] = r[7] ^ c;
      if (hup) e[5] = v[3];
      wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, e});
      // the flags pin must show the same flags
      compares++;
      if (flags !== e) begin
        mismatches++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, flags, e);
      end
      chk_reg(4'h3, r);
    end
    // direct and pointer transfers, pointer carry across bytes
    v = $random(seed);
    set_reg(4'h1, v);
    ex(cpu_exec_pkg::op_direct_store, 2'd0, 2'd0, 4'h1, 3'd0, 1'b0, 8'hff);
    ex(cpu_exec_pkg::op_direct_load, 2'd0, 2'd0, 4'h2, 3'd0, 1'b0, 8'hff);
    chk_reg(4'h2, v);
    set_reg(4'he, 8'hff);
    set_reg(4'hf, 8'h00);
    ex(cpu_exec_pkg::op_indirect_load, 2'd1, 2'd2, 4'h4, 3'd0, 1'b0, 8'h0);
    chk_reg(4'h4, v);
    chk_reg(4'he, 8'h00);
    chk_reg(4'hf, 8'h01);
    ex(cpu_exec_pkg::op_indirect_load, 2'd2, 2'd2, 4'h5, 3'd0, 1'b0, 8'h0);
    chk_reg(4'h5, v);
    chk_reg(4'hf, 8'h00);
    set_reg(4'h6, ~v);
    ex(cpu_exec_pkg::op_indirect_store, 2'd2, 2'd2, 4'h6, 3'd0, 1'b0, 8'h0);
    ex(cpu_exec_pkg::op_direct_load, 2'd0, 2'd0, 4'h7, 3'd0, 1'b0, 8'hfe);
    chk_reg(4'h7, ~v);
    ex(cpu_exec_pkg::op_indirect_store, 2'd0, 2'd2, 4'h1, 3'd0, 1'b0, 8'h0);
    ex(cpu_exec_pkg::op_indirect_load, 2'd0, 2'd2, 4'h8, 3'd0, 1'b0, 8'h0);
    chk_reg(4'h8, v);
    chk_reg(4'he, 8'hfe);
    // stack push then pop keeps the flags
    v = $random(seed);
    f = $random(seed);
    set_reg(4'h9, v);
    wb(1'b1, 4'h8, {24'h0, f}, 32'h0, 32'h0);
    ex(cpu_exec_pkg::op_push, 2'd0, 2'd0, 4'h9, 3'd0, 1'b0, 8'h0);
    ex(cpu_exec_pkg::op_pop, 2'd0, 2'd0, 4'ha, 3'd0, 1'b0, 8'h0);
    wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f});
    chk_reg(4'ha, v);
    // i/o bit set and clear below and above the bit-addressable range
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      f = $random(seed);
      b3 = $random(seed);
      off = i[1] ? 8'h25 : 8'h05;
      set_reg(4'hb, v);
      wb(1'b1, 4'h8, {24'h0, f}, 32'h0, 32'h0);
      ex(cpu_exec_pkg::op_io_out, 2'd0, 2'd0, 4'hb, 3'd0, 1'b0, off);
      sop = i[0] ? cpu_exec_pkg::op_io_bit_clear : cpu_exec_pkg::op_io_bit_set;
      ex(sop, 2'd0, 2'd0, 4'h0, b3, 1'b0, off);
      ex(cpu_exec_pkg::op_io_in, 2'd0, 2'd0, 4'hc, 3'd0, 1'b0, off);
      wb(1'b0, 4'h8, 32'h0, 32'hff, {24'h0, f});
      e = v;
      if (!i[1]) e[b3] = ~i[0];
      chk_reg(4'hc, e);
    end
    end_sim();
  end
endmodule
`default_nettype wire
